// ---- core/psr_pkg.sv ----
package psr_pkg;

  localparam logic [4:0]  REG_XOVER_CTRL   = 5'h10;
  localparam logic [4:0]  REG_LINK_STATUS  = 5'h11;
  localparam logic [4:0]  REG_IRQ_ENABLE   = 5'h12;
  localparam logic [4:0]  REG_IRQ_STATUS   = 5'h13;

  localparam int unsigned ST_RATE_LO       = 14;
  localparam int unsigned ST_DUPLEX        = 13;
  localparam int unsigned ST_PAGE          = 12;
  localparam int unsigned ST_RESOLVED      = 11;
  localparam int unsigned ST_LINK          = 10;
  localparam int unsigned ST_XOVER         = 6;
  localparam int unsigned ST_DOWNGRADE     = 5;
  localparam int unsigned ST_TX_PAUSE      = 3;
  localparam int unsigned ST_RX_PAUSE      = 2;
  localparam int unsigned ST_POLARITY      = 1;
  localparam int unsigned ST_JABBER        = 0;

  localparam int unsigned IRQ_NEG_FAULT    = 15;
  localparam int unsigned IRQ_RATE         = 14;
  localparam int unsigned IRQ_DUPLEX       = 13;
  localparam int unsigned IRQ_PAGE         = 12;
  localparam int unsigned IRQ_LINK_FAIL    = 11;
  localparam int unsigned IRQ_LINK_UP      = 10;
  localparam int unsigned IRQ_WAKE         = 6;
  localparam int unsigned IRQ_DOWNGRADE    = 5;
  localparam int unsigned IRQ_POLARITY     = 1;
  localparam int unsigned IRQ_JABBER       = 0;

  localparam logic [15:0] IRQ_ENABLE_MASK  = 16'hFC63;
  localparam logic [15:0] IRQ_ENABLE_RST   = 16'h0000;
  localparam logic [15:0] IRQ_STATUS_RST   = 16'h0000;

  localparam int unsigned XOVER_FIELD_LO   = 5;
  localparam logic [1:0]  XOVER_AUTO       = 2'h3;
  localparam logic [1:0]  XOVER_RESERVED   = 2'h2;
  localparam logic [1:0]  XOVER_CROSSED    = 2'h1;
  localparam logic [1:0]  XOVER_STRAIGHT   = 2'h0;
  localparam logic [1:0]  XOVER_RST        = 2'h3;

  localparam logic [5:0]  MDIO_PREAMBLE    = 6'h20;
  localparam logic [5:0]  MDIO_OP_LAST     = 6'h01;
  localparam logic [5:0]  MDIO_ADDR_LAST   = 6'h04;
  localparam logic [5:0]  MDIO_TA_LAST     = 6'h01;
  localparam logic [5:0]  MDIO_DATA_LAST   = 6'h0F;
  localparam logic [1:0]  MDIO_OP_READ     = 2'h2;
  localparam logic [1:0]  MDIO_OP_WRITE    = 2'h1;

  typedef enum logic [2:0] {
    MS_IDLE  = 3'h0,
    MS_START = 3'h1,
    MS_OP    = 3'h3,
    MS_PHYAD = 3'h2,
    MS_REGAD = 3'h6,
    MS_TA    = 3'h7,
    MS_DATA  = 3'h5
  } psr_mdio_state_t;

endpackage

// ---- core/psr_evt_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface psr_evt_if #(
  parameter int unsigned W = 16
);
  logic [W-1:0] evt;
  logic [W-1:0] clr;
  logic [W-1:0] sticky;

  modport latch (input evt, input clr, output sticky);
  modport owner (output evt, output clr, input sticky);
endinterface
`default_nettype wire

// ---- core/psr_evt_latch.sv ----
`timescale 1ns/100ps
`default_nettype none
module psr_evt_latch #(
  parameter int unsigned W = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  psr_evt_if.latch  ev_if
);

  logic [W-1:0] sticky_r;

  assign ev_if.sticky = sticky_r;

  // One sticky flag per source, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sticky_r[gi] <= 1'b0;
        end else if (ev_if.evt[gi]) begin
          sticky_r[gi] <= 1'b1;
        end else if (ev_if.clr[gi]) begin
          sticky_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- core/psr_phy_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module psr_phy_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       sw_reset_i,
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_n_o,
  input  wire logic [1:0] resolved_rate_i,
  input  wire logic       full_duplex_i,
  input  wire logic       link_up_i,
  input  wire logic       aneg_enable_i,
  input  wire logic       aneg_done_i,
  input  wire logic       forced_mode_i,
  input  wire logic       auto_crossed_i,
  input  wire logic       tx_pause_res_i,
  input  wire logic       rx_pause_res_i,
  input  wire logic       rate_downgrade_i,
  input  wire logic       pair_sign_rev_i,
  input  wire logic       overlong_tx_i,
  input  wire logic       page_rx_i,
  input  wire logic       negotiation_fault_i,
  input  wire logic       wake_event_i,
  output logic [1:0]      pair_swap_mode_o,
  output logic            irq_n_o
);

  // Management frame state
  psr_pkg::psr_mdio_state_t state_r;
  psr_pkg::psr_mdio_state_t state_nxt;
  logic        mdc_q_r;
  logic [5:0]  cnt_r;
  logic [1:0]  op_r;
  logic [4:0]  phyad_r;
  logic [4:0]  regad_r;
  logic [15:0] shift_r;
  logic        rd_act_r;
  logic        wr_act_r;

  // Register state
  logic [15:0] irq_enable_r;
  logic [1:0]  pair_swap_cfg_r;
  logic [1:0]  pair_swap_mode_r;
  logic        page_seen_r;
  logic        mdio_r;
  logic        mdio_oe_n_r;
  logic        irq_n_r;

  // Previous status for change detection
  logic [1:0]  rate_q_r;
  logic        duplex_q_r;
  logic        link_q_r;
  logic        downgrade_q_r;
  logic        polarity_q_r;
  logic        jabber_q_r;

  psr_evt_if #(.W(16)) irq_if ();

  psr_evt_latch #(
    .W (16)
  ) u_irq_status (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ev_if     (irq_if.latch)
  );

  // Edge of the management clock
  wire mdc_rise = mdc_i & ~mdc_q_r;
  wire bit_in   = mdio_i;

  // Address seen at the last register address bit
  wire [4:0] regad_full = {regad_r[3:0], bit_in};
  wire       phy_match  = (phyad_r == PHY_ADDR);
  wire       last_regad = mdc_rise && (state_r == psr_pkg::MS_REGAD)
                          && (cnt_r == psr_pkg::MDIO_ADDR_LAST);
  wire       rd_take    = last_regad && phy_match && (op_r == psr_pkg::MDIO_OP_READ);
  wire       wr_frame   = last_regad && phy_match && (op_r == psr_pkg::MDIO_OP_WRITE);
  wire       data_last  = mdc_rise && (state_r == psr_pkg::MS_DATA)
                          && (cnt_r == psr_pkg::MDIO_DATA_LAST);
  wire       wr_commit  = data_last && wr_act_r;
  wire [15:0] wr_data   = {shift_r[14:0], bit_in};

  wire rd_status  = rd_take && (regad_full == psr_pkg::REG_LINK_STATUS);
  wire rd_irq_st  = rd_take && (regad_full == psr_pkg::REG_IRQ_STATUS);
  wire wr_irq_en  = wr_commit && (regad_r == psr_pkg::REG_IRQ_ENABLE);
  wire wr_xover   = wr_commit && (regad_r == psr_pkg::REG_XOVER_CTRL);

  // Resolution and crossover report
  wire resolved   = ~aneg_enable_i | aneg_done_i;
  wire mode_auto  = (pair_swap_mode_r == psr_pkg::XOVER_AUTO)
                    || (pair_swap_mode_r == psr_pkg::XOVER_RESERVED);
  wire crossed    = mode_auto ? auto_crossed_i
                    : (pair_swap_mode_r == psr_pkg::XOVER_CROSSED);
  wire xover_bit  = resolved & crossed;
  wire tx_pause   = ~forced_mode_i & resolved & tx_pause_res_i;
  wire rx_pause   = ~forced_mode_i & resolved & rx_pause_res_i;

  // Status word, reserved bits zero
  logic [15:0] status_word;
  always_comb begin
    status_word                                          = 16'h0000;
    status_word[psr_pkg::ST_RATE_LO+1:psr_pkg::ST_RATE_LO] = resolved_rate_i;
    status_word[psr_pkg::ST_DUPLEX]                      = full_duplex_i;
    status_word[psr_pkg::ST_PAGE]                        = page_seen_r;
    status_word[psr_pkg::ST_RESOLVED]                    = resolved;
    status_word[psr_pkg::ST_LINK]                        = link_up_i;
    status_word[psr_pkg::ST_XOVER]                       = xover_bit;
    status_word[psr_pkg::ST_DOWNGRADE]                   = rate_downgrade_i;
    status_word[psr_pkg::ST_TX_PAUSE]                    = tx_pause;
    status_word[psr_pkg::ST_RX_PAUSE]                    = rx_pause;
    status_word[psr_pkg::ST_POLARITY]                    = pair_sign_rev_i;
    status_word[psr_pkg::ST_JABBER]                      = overlong_tx_i;
  end

  wire [15:0] xover_word = {9'h000, pair_swap_cfg_r, 5'h00};

  // Read data select
  wire [15:0] rd_word =
      (regad_full == psr_pkg::REG_LINK_STATUS) ? status_word :
      (regad_full == psr_pkg::REG_IRQ_ENABLE)  ? irq_enable_r :
      (regad_full == psr_pkg::REG_IRQ_STATUS)  ? irq_if.sticky :
      (regad_full == psr_pkg::REG_XOVER_CTRL)  ? xover_word : 16'h0000;

  // Event sources
  logic [15:0] evt_vec;
  always_comb begin
    evt_vec                          = 16'h0000;
    evt_vec[psr_pkg::IRQ_NEG_FAULT]  = negotiation_fault_i;
    evt_vec[psr_pkg::IRQ_RATE]       = (resolved_rate_i != rate_q_r);
    evt_vec[psr_pkg::IRQ_DUPLEX]     = full_duplex_i ^ duplex_q_r;
    evt_vec[psr_pkg::IRQ_PAGE]       = page_rx_i;
    evt_vec[psr_pkg::IRQ_LINK_FAIL]  = link_q_r & ~link_up_i;
    evt_vec[psr_pkg::IRQ_LINK_UP]    = ~link_q_r & link_up_i;
    evt_vec[psr_pkg::IRQ_WAKE]       = wake_event_i;
    evt_vec[psr_pkg::IRQ_DOWNGRADE]  = rate_downgrade_i & ~downgrade_q_r;
    evt_vec[psr_pkg::IRQ_POLARITY]   = pair_sign_rev_i ^ polarity_q_r;
    evt_vec[psr_pkg::IRQ_JABBER]     = overlong_tx_i & ~jabber_q_r;
  end

  assign irq_if.evt = evt_vec;
  assign irq_if.clr = (rd_irq_st || sw_reset_i) ? 16'hFFFF : 16'h0000;

  // Gated interrupt request
  wire irq_any = |(irq_if.sticky & irq_enable_r);

  // Frame sequencing
  always_comb begin
    state_nxt = state_r;
    if (mdc_rise) begin
      case (state_r)
        psr_pkg::MS_IDLE: begin
          if (!bit_in && cnt_r == psr_pkg::MDIO_PREAMBLE) begin
            state_nxt = psr_pkg::MS_START;
          end
        end
        psr_pkg::MS_START: begin
          state_nxt = bit_in ? psr_pkg::MS_OP : psr_pkg::MS_IDLE;
        end
        psr_pkg::MS_OP: begin
          if (cnt_r == psr_pkg::MDIO_OP_LAST) begin
            state_nxt = psr_pkg::MS_PHYAD;
          end
        end
        psr_pkg::MS_PHYAD: begin
          if (cnt_r == psr_pkg::MDIO_ADDR_LAST) begin
            state_nxt = psr_pkg::MS_REGAD;
          end
        end
        psr_pkg::MS_REGAD: begin
          if (cnt_r == psr_pkg::MDIO_ADDR_LAST) begin
            state_nxt = psr_pkg::MS_TA;
          end
        end
        psr_pkg::MS_TA: begin
          if (cnt_r == psr_pkg::MDIO_TA_LAST) begin
            state_nxt = psr_pkg::MS_DATA;
          end
        end
        psr_pkg::MS_DATA: begin
          if (cnt_r == psr_pkg::MDIO_DATA_LAST) begin
            state_nxt = psr_pkg::MS_IDLE;
          end
        end
        default: begin
          state_nxt = psr_pkg::MS_IDLE;
        end
      endcase
    end
  end

  wire field_end = (state_nxt != state_r);
  wire [5:0] cnt_nxt =
      (state_r == psr_pkg::MS_IDLE) ?
        (!bit_in ? 6'h00 : (cnt_r == psr_pkg::MDIO_PREAMBLE) ? cnt_r : cnt_r + 6'h01) :
      field_end ? 6'h00 : cnt_r + 6'h01;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= psr_pkg::MS_IDLE;
      cnt_r   <= 6'h00;
      mdc_q_r <= 1'b0;
    end else begin
      mdc_q_r <= mdc_i;
      state_r <= state_nxt;
      if (mdc_rise) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // Field capture
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_r    <= 2'h0;
      phyad_r <= 5'h00;
      regad_r <= 5'h00;
    end else if (mdc_rise) begin
      if (state_r == psr_pkg::MS_OP) begin
        op_r <= {op_r[0], bit_in};
      end
      if (state_r == psr_pkg::MS_PHYAD) begin
        phyad_r <= {phyad_r[3:0], bit_in};
      end
      if (state_r == psr_pkg::MS_REGAD) begin
        regad_r <= regad_full;
      end
    end
  end

  // Data shift and pin drive
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r     <= 16'h0000;
      rd_act_r    <= 1'b0;
      wr_act_r    <= 1'b0;
      mdio_r      <= 1'b1;
      mdio_oe_n_r <= 1'b1;
    end else if (mdc_rise) begin
      if (last_regad) begin
        rd_act_r <= rd_take;
        wr_act_r <= wr_frame;
        shift_r  <= rd_take ? rd_word : 16'h0000;
      end else if (state_r == psr_pkg::MS_TA) begin
        if (rd_act_r && cnt_r == 6'h00) begin
          mdio_r      <= 1'b0;
          mdio_oe_n_r <= 1'b0;
        end else if (rd_act_r) begin
          mdio_r  <= shift_r[15];
          shift_r <= {shift_r[14:0], 1'b0};
        end
      end else if (state_r == psr_pkg::MS_DATA) begin
        if (rd_act_r && !data_last) begin
          mdio_r  <= shift_r[15];
          shift_r <= {shift_r[14:0], 1'b0};
        end else if (wr_act_r) begin
          shift_r <= wr_data;
        end
        if (data_last) begin
          mdio_oe_n_r <= 1'b1;
          mdio_r      <= 1'b1;
          rd_act_r    <= 1'b0;
          wr_act_r    <= 1'b0;
        end
      end else if (state_r == psr_pkg::MS_IDLE) begin
        mdio_oe_n_r <= 1'b1;
        rd_act_r    <= 1'b0;
        wr_act_r    <= 1'b0;
      end
    end
  end

  // Writable registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable_r     <= psr_pkg::IRQ_ENABLE_RST;
      pair_swap_cfg_r  <= psr_pkg::XOVER_RST;
      pair_swap_mode_r <= psr_pkg::XOVER_RST;
    end else begin
      if (sw_reset_i) begin
        irq_enable_r     <= psr_pkg::IRQ_ENABLE_RST;
        pair_swap_mode_r <= pair_swap_cfg_r;
      end else if (wr_irq_en) begin
        irq_enable_r <= wr_data & psr_pkg::IRQ_ENABLE_MASK;
      end
      if (wr_xover) begin
        pair_swap_cfg_r <= wr_data[psr_pkg::XOVER_FIELD_LO+1:psr_pkg::XOVER_FIELD_LO];
      end
    end
  end

  // Page arrival latch, clear on status read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_seen_r <= 1'b0;
    end else if (page_rx_i) begin
      page_seen_r <= 1'b1;
    end else if (rd_status || sw_reset_i) begin
      page_seen_r <= 1'b0;
    end
  end

  // Change detection history
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_q_r      <= 2'h0;
      duplex_q_r    <= 1'b0;
      link_q_r      <= 1'b0;
      downgrade_q_r <= 1'b0;
      polarity_q_r  <= 1'b0;
      jabber_q_r    <= 1'b0;
    end else begin
      rate_q_r      <= resolved_rate_i;
      duplex_q_r    <= full_duplex_i;
      link_q_r      <= link_up_i;
      downgrade_q_r <= rate_downgrade_i;
      polarity_q_r  <= pair_sign_rev_i;
      jabber_q_r    <= overlong_tx_i;
    end
  end

  // Registered interrupt output
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~irq_any;
    end
  end

  assign mdio_o           = mdio_r;
  assign mdio_oe_n_o      = mdio_oe_n_r;
  assign irq_n_o          = irq_n_r;
  assign pair_swap_mode_o = pair_swap_mode_r;

endmodule
`default_nettype wire

// ---- testbench/psr_phy_regs_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module psr_phy_regs_props (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       sw_reset_i,
  input wire logic       mdc_i,
  input wire logic       mdio_o,
  input wire logic       mdio_oe_n_o,
  input wire logic [1:0] resolved_rate_i,
  input wire logic       full_duplex_i,
  input wire logic       link_up_i,
  input wire logic       rate_downgrade_i,
  input wire logic       pair_sign_rev_i,
  input wire logic       overlong_tx_i,
  input wire logic       page_rx_i,
  input wire logic       negotiation_fault_i,
  input wire logic       wake_event_i,
  input wire logic [1:0] pair_swap_mode_o,
  input wire logic       irq_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic       mdc_q_r;
  logic [6:0] lv_q_r;
  logic [3:0] since_mdc_r;
  logic [3:0] since_cause_r;
  logic [4:0] rd_rises_r;
  logic [6:0] lv;
  logic       mdc_rise;
  logic       cause;

  assign lv = {resolved_rate_i, full_duplex_i, link_up_i, rate_downgrade_i, pair_sign_rev_i,
               overlong_tx_i};
  assign mdc_rise = mdc_i & ~mdc_q_r;
  assign cause = mdc_rise | page_rx_i | negotiation_fault_i | wake_event_i | (lv != lv_q_r);

  // Cycle counters since management clock rise and since any interrupt cause
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdc_q_r       <= 1'b0;
      lv_q_r        <= 7'h00;
      since_mdc_r   <= 4'hF;
      since_cause_r <= 4'h0;
      rd_rises_r    <= 5'h00;
    end else begin
      mdc_q_r       <= mdc_i;
      lv_q_r        <= lv;
      since_mdc_r   <= mdc_rise ? 4'h0 : (since_mdc_r == 4'hF ? 4'hF : since_mdc_r + 4'h1);
      since_cause_r <= cause ? 4'h0 : (since_cause_r == 4'hF ? 4'hF : since_cause_r + 4'h1);
      rd_rises_r    <= mdio_oe_n_o ? 5'h00 : rd_rises_r + {4'h0, mdc_rise};
    end
  end

  property p_swap_hold;
    $changed(pair_swap_mode_o) |-> $past(sw_reset_i);
  endproperty
  a_swap_hold: assert property (p_swap_hold) else $error("swap mode moved without reset");
  property p_sw_quiet;
    sw_reset_i |-> ##2 irq_n_o;
  endproperty
  a_sw_quiet: assert property (p_sw_quiet) else $error("irq active after soft reset");
  property p_irq_rise;
    $rose(irq_n_o) |-> since_mdc_r < 4'h6 || $past(sw_reset_i) || $past(sw_reset_i, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq released without access");
  property p_irq_fall;
    $fell(irq_n_o) |-> since_cause_r < 4'h6;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq raised without cause");
  property p_ta_zero;
    $fell(mdio_oe_n_o) |-> !mdio_o;
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
  property p_idle_high;
    mdio_oe_n_o |-> mdio_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("data out not idle high");
  property p_read_len;
    $rose(mdio_oe_n_o) |-> rd_rises_r == 5'h11;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read drive length wrong");
  property p_drive_step;
    !mdio_oe_n_o && $changed(mdio_o) |-> since_mdc_r < 4'h4;
  endproperty
  a_drive_step: assert property (p_drive_step) else $error("data out moved off clock");
endmodule

bind psr_phy_regs psr_phy_regs_props u_psr_phy_regs_props (
  .clk_sys_i, .rst_n_i, .sw_reset_i, .mdc_i, .mdio_o, .mdio_oe_n_o, .resolved_rate_i,
  .full_duplex_i, .link_up_i, .rate_downgrade_i, .pair_sign_rev_i, .overlong_tx_i, .page_rx_i,
  .negotiation_fault_i, .wake_event_i, .pair_swap_mode_o, .irq_n_o
);
`default_nettype wire

// ---- testbench/psr_mgmt_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module psr_mgmt_master (
  input  wire logic   clk_sys_i,
  input  wire logic   mdio_line_i,
  output logic        mdc_o,
  output logic        mdio_drv_o,
  output logic [15:0] rd_data_o,
  output logic        rd_valid_o
);
  initial begin
    mdc_o      = 1'b0;
    mdio_drv_o = 1'b1;
    rd_data_o  = 16'h0000;
    rd_valid_o = 1'b0;
  end

  // One bit: three cycles low, three high; line sampled before the rise
  task automatic bit_out(input logic b, output logic s);
    @(negedge clk_sys_i);
    mdio_drv_o = b;
    repeat (2) @(negedge clk_sys_i);
    s = mdio_line_i;
    mdc_o = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    mdc_o = 1'b0;
  endtask

  // Released bits drive 1 to stand for the pull-up
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       input logic [4:0] pa);
    logic [63:0] bits;
    logic        s;
    logic [15:0] rd;
    bits = {32'hFFFFFFFF, 2'h1, op, pa, ra, (op == 2'h1) ? 2'h2 : 2'h3,
            (op == 2'h1) ? wd : 16'hFFFF};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      bit_out(bits[i], s);
      if (i < 16) rd = {rd[14:0], s};
    end
    if (op == 2'h2) begin
      @(negedge clk_sys_i);
      rd_data_o = rd;
      rd_valid_o = 1'b1;
      @(negedge clk_sys_i);
      rd_valid_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_phy_status_and_irq_enable_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_phy_status_and_irq_enable_regs;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        sw_reset_i = 1'b0;
  logic        mdc, mdio_drv, mdio_o, mdio_oe_n_o, mdio_line, irq_n_o, rd_valid;
  logic [1:0]  pair_swap_mode_o;
  logic [15:0] rd_data;
  logic [12:0] lv = 13'h0000;
  logic [2:0]  pl = 3'h0;
  logic [15:0] exp_q[$];
  logic [15:0] rnd = 16'hD789;
  logic [15:0] stat, en;
  logic [1:0]  mode;
  logic        page_b;
  int          miscompares = 0;
  int          checks_done = 0;

  always #10 clk_sys_i = ~clk_sys_i;
  assign mdio_line = mdio_oe_n_o ? mdio_drv : mdio_o;

  psr_phy_regs u_psr_phy_regs (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sw_reset_i(sw_reset_i), .mdc_i(mdc),
    .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o),
    .resolved_rate_i(lv[1:0]), .full_duplex_i(lv[2]), .link_up_i(lv[3]),
    .aneg_enable_i(lv[4]), .aneg_done_i(lv[5]), .forced_mode_i(lv[6]), .auto_crossed_i(lv[7]),
    .tx_pause_res_i(lv[8]), .rx_pause_res_i(lv[9]), .rate_downgrade_i(lv[10]),
    .pair_sign_rev_i(lv[11]), .overlong_tx_i(lv[12]), .page_rx_i(pl[0]),
    .negotiation_fault_i(pl[1]), .wake_event_i(pl[2]), .pair_swap_mode_o(pair_swap_mode_o),
    .irq_n_o(irq_n_o)
  );

  psr_mgmt_master u_psr_mgmt_master (
    .clk_sys_i(clk_sys_i), .mdio_line_i(mdio_line), .mdc_o(mdc), .mdio_drv_o(mdio_drv),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] phys();
    logic res;
    logic xo;
    res = !lv[4] | lv[5];
    xo = res & ((mode == psr_pkg::XOVER_CROSSED) | (mode[1] & lv[7]));
    return {lv[1:0], lv[2], page_b, res, lv[3], 3'h0, xo, lv[10], 1'b0,
            !lv[6] & res & lv[8], !lv[6] & res & lv[9], lv[11], lv[12]};
  endfunction

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [1:0] e, input logic [1:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] e, input logic [4:0] pa = 5'h00);
    exp_q.push_back(e);
    u_psr_mgmt_master.frame(2'h2, ra, 16'h0000, pa);
    @(negedge clk_sys_i);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_psr_mgmt_master.frame(2'h1, ra, d, 5'h00);
    repeat (3) @(negedge clk_sys_i);
  endtask

  // New levels and pulses; expected event bits follow the edges
  task automatic set_in(input logic [15:0] r);
    logic [12:0] o;
    o = lv;
    @(negedge clk_sys_i);
    lv = r[12:0];
    pl = r[15:13];
    if (lv[1:0] != o[1:0]) stat[14] = 1'b1;
    if (lv[2] != o[2]) stat[13] = 1'b1;
    if (o[3] && !lv[3]) stat[11] = 1'b1;
    if (!o[3] && lv[3]) stat[10] = 1'b1;
    if (!o[10] && lv[10]) stat[5] = 1'b1;
    if (lv[11] != o[11]) stat[1] = 1'b1;
    if (!o[12] && lv[12]) stat[0] = 1'b1;
    stat = stat | {pl[1], 2'h0, pl[0], 5'h00, pl[2], 6'h00};
    page_b = page_b | pl[0];
    @(negedge clk_sys_i);
    pl = 3'h0;
    repeat (6) @(negedge clk_sys_i);
  endtask

  task automatic finish_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    if (rd_valid) chk_word("read", exp_q.pop_front(), rd_data);
  end

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    miscompares++;
    finish_test();
  end

  initial begin
    stat = 16'h0000;
    en = 16'h0000;
    mode = psr_pkg::XOVER_RST;
    page_b = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk_pin("swap", psr_pkg::XOVER_RST, pair_swap_mode_o);
    rd(psr_pkg::REG_IRQ_ENABLE, 16'h0000);
    rd(psr_pkg::REG_XOVER_CTRL, 16'h0060);
    wr(psr_pkg::REG_LINK_STATUS, 16'hFFFF);
    rd(psr_pkg::REG_LINK_STATUS, phys());
    rd(5'h05, 16'h0000);
    rd(psr_pkg::REG_IRQ_ENABLE, 16'hFFFF, 5'h1F);
    wr(psr_pkg::REG_IRQ_ENABLE, 16'hFFFF);
    rd(psr_pkg::REG_IRQ_ENABLE, 16'hFC63);
    en = 16'hFC63;
    set_in(16'h2000);
    chk_pin("irq", 2'h0, {1'b0, irq_n_o});
    rd(psr_pkg::REG_LINK_STATUS, phys());
    page_b = 1'b0;
    rd(psr_pkg::REG_LINK_STATUS, phys());
    rd(psr_pkg::REG_IRQ_STATUS, stat);
    stat = 16'h0000;
    for (int m = 0; m < 4; m++) begin
      wr(psr_pkg::REG_XOVER_CTRL, 16'hFF9F | {9'h000, 2'(m), 5'h00});
      chk_pin("swap", mode, pair_swap_mode_o);
      rd(psr_pkg::REG_XOVER_CTRL, {9'h000, 2'(m), 5'h00});
      @(negedge clk_sys_i);
      sw_reset_i = 1'b1;
      @(negedge clk_sys_i);
      sw_reset_i = 1'b0;
      mode = 2'(m);
      stat = 16'h0000;
      page_b = 1'b0;
      @(negedge clk_sys_i);
      chk_pin("swap", mode, pair_swap_mode_o);
      rd(psr_pkg::REG_IRQ_ENABLE, 16'h0000);
      for (int k = 0; k < 3; k++) begin
        rnd = lfsr(rnd);
        set_in(rnd);
        rnd = lfsr(rnd);
        wr(psr_pkg::REG_IRQ_ENABLE, rnd);
        en = rnd & psr_pkg::IRQ_ENABLE_MASK;
        chk_pin("irq", {1'b0, ~|(stat & en)}, {1'b0, irq_n_o});
        rd(psr_pkg::REG_LINK_STATUS, phys());
        page_b = 1'b0;
        rd(psr_pkg::REG_IRQ_STATUS, stat);
        stat = 16'h0000;
        repeat (3) @(negedge clk_sys_i);
        chk_pin("irq", 2'h1, {1'b0, irq_n_o});
      end
    end
    repeat (4) @(negedge clk_sys_i);
    finish_test();
  end
endmodule
`default_nettype wire
